// ---- rtl/ecl_pkg.sv ----
package ecl_pkg;

    // ------------------------------------------------------------------
    // Image layout and defaults
    // ------------------------------------------------------------------
    localparam int          ECL_NPORTS     = 4;
    localparam int          ECL_NPM_PORTS  = 3;
    localparam int          ECL_NWORDS     = 15;
    localparam int          ECL_IDX_W      = 4;
    localparam logic [7:0]  ECL_BASE_ADDR  = 8'h38;
    localparam int          ECL_IDX_CSR_LO = 0;
    localparam int          ECL_IDX_PHY    = 4;
    localparam int          ECL_IDX_CSR_HI = 8;
    localparam int          ECL_IDX_PM     = 12;
    localparam logic [15:0] ECL_DEF_CSR_LO = 16'h0000;
    localparam logic [15:0] ECL_DEF_PHY_P0 = 16'h001D;
    localparam logic [15:0] ECL_DEF_PHY    = 16'h101D;
    localparam logic [15:0] ECL_DEF_CSR_HI = 16'h000F;
    localparam logic [15:0] ECL_DEF_PM     = 16'h00FF;

    // ------------------------------------------------------------------
    // Register bus map
    // ------------------------------------------------------------------
    localparam logic [11:0] ECL_REG_CTRL   = 12'h000;
    localparam logic [11:0] ECL_REG_STATUS = 12'h004;
    localparam logic [11:0] ECL_REG_IMAGE  = 12'h100;
    localparam int          ECL_CTRL_RELOAD = 0;
    localparam int          ECL_ST_BUSY     = 0;
    localparam int          ECL_ST_DONE     = 1;
    localparam int          ECL_ST_ABSENT   = 2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0]  phy_param2;
        logic [6:0]  phy_param3;
        logic        deemph_sel;
        logic        compl_to_detect;
        logic [1:0]  data_change_count_select;
        logic [31:0] phy_pipe_control_word;
        logic        no_soft_reset;
        logic [2:0]  aux_current;
        logic        d1_support;
        logic        d2_support;
        logic [1:0]  pme_support;
        logic [7:0]  pm_data;
    } ecl_cfg_port_s;

    typedef enum logic [2:0] {
        ECL_LD_BOOT  = 3'b001,
        ECL_LD_BUSY  = 3'b010,
        ECL_LD_READY = 3'b100
    } ecl_load_e;

    typedef enum logic [2:0] {
        ECL_FT_IDLE = 3'b001,
        ECL_FT_REQ  = 3'b010,
        ECL_FT_NEXT = 3'b100
    } ecl_fetch_e;

    function automatic logic [15:0] ecl_default_word(input logic [3:0] idx);
        logic [15:0] w;
        w = ECL_DEF_CSR_LO;
        if (idx == 4'(ECL_IDX_PHY)) begin
            w = ECL_DEF_PHY_P0;
        end else if (idx > 4'(ECL_IDX_PHY) && idx < 4'(ECL_IDX_CSR_HI)) begin
            w = ECL_DEF_PHY;
        end else if (idx >= 4'(ECL_IDX_CSR_HI) && idx < 4'(ECL_IDX_PM)) begin
            w = ECL_DEF_CSR_HI;
        end else if (idx >= 4'(ECL_IDX_PM)) begin
            w = ECL_DEF_PM;
        end
        return w;
    endfunction

endpackage

// ---- rtl/ecl_image_ram.sv ----
`timescale 1ns/1ns
`default_nettype none
module ecl_image_ram
    import ecl_pkg::*;
#(
    parameter int DEPTH = ECL_NWORDS,
    parameter int AW    = ECL_IDX_W
) (
    // Clock
    input  wire logic          pclk,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [15:0]   wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [15:0]   rdata
);

    logic [15:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk) begin
        rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : 16'h0000;
    end

endmodule
`default_nettype wire

// ---- rtl/ecl_word_fetch.sv ----
`timescale 1ns/1ns
`default_nettype none
module ecl_word_fetch
    import ecl_pkg::*;
(
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Control
    input  wire logic                 start,
    output logic                      busy,
    output logic                      done,
    // Configuration memory
    output logic                      mem_req,
    output logic [7:0]                mem_addr,
    input  wire logic                 mem_ack,
    input  wire logic                 mem_absent,
    input  wire logic [15:0]          mem_rdata,
    // Fetched words
    output logic                      word_valid,
    output logic [ECL_IDX_W-1:0]      word_idx,
    output logic [15:0]               word_data,
    output logic                      word_absent
);

    ecl_fetch_e           state;
    logic [ECL_IDX_W-1:0] idx;

    assign mem_req  = (state == ECL_FT_REQ);
    assign mem_addr = 8'(ECL_BASE_ADDR + {3'b000, idx, 1'b0});
    assign busy     = (state != ECL_FT_IDLE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ECL_FT_IDLE;
            idx   <= '0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                ECL_FT_IDLE: begin
                    if (start) begin
                        idx   <= '0;
                        state <= ECL_FT_REQ;
                    end
                end
                ECL_FT_REQ: begin
                    if (mem_ack) begin
                        if (idx == 4'(ECL_NWORDS - 1)) begin
                            done  <= 1'b1;
                            state <= ECL_FT_IDLE;
                        end else begin
                            state <= ECL_FT_NEXT;
                        end
                    end
                end
                ECL_FT_NEXT: begin
                    idx   <= 4'(idx + 4'h1);
                    state <= ECL_FT_REQ;
                end
                default: begin
                    state <= ECL_FT_IDLE;
                end
            endcase
        end
    end

    // Absent words are replaced by their default so the fields keep it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_valid  <= 1'b0;
            word_idx    <= '0;
            word_data   <= 16'h0000;
            word_absent <= 1'b0;
        end else begin
            word_valid <= (state == ECL_FT_REQ) && mem_ack;
            if ((state == ECL_FT_REQ) && mem_ack) begin
                word_idx    <= idx;
                word_absent <= mem_absent;
                word_data   <= mem_absent ? ecl_default_word(idx) : mem_rdata;
            end
        end
    end

endmodule
`default_nettype wire

// ---- rtl/ecl_loader.sv ----
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Port 3 phy word bits 4:0 go to 7Ch bits 12:8; default 101Dh.
// - Phy word bits 11:5 go to 90h bits 6:0 per port.
// - Phy word bit 12 goes to F0h bit 6, de-emphasis select.
// - Phy word bit 13 goes to 78h bit 11, compliance to detect.
// - Phy word bits 15:14 go to 8Ch bits 9:8, data change count select.
// - Words 48h..4Eh fill 80h bits 31:16 of ports 0..3; default 000Fh.
// - Bit 0 of words 50h..54h gives 44h bit 3, no soft reset.
// - Power word bits 3:1 go to 40h bits 24:22, aux current.
// - 40h bit 25 reads as constant 1, D1 supported.
// - 40h bit 26 reads as constant 1, D2 supported.
// - Power word bits 7:6 go to 40h bits 29:28, event support.
// - Power word bits 15:8 go to 44h bits 31:24; default 00h.
// - Words 38h..3Eh fill 80h bits 15:0 of ports 0..3; default 0000h.
module ecl_loader
    import ecl_pkg::*;
(
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Configuration memory
    output logic                               mem_req,
    output logic      [7:0]                    mem_addr,
    input  wire logic                          mem_ack,
    input  wire logic                          mem_absent,
    input  wire logic [15:0]                   mem_rdata,
    // Port configuration
    output ecl_cfg_port_s [ECL_NPORTS-1:0]     port_cfg,
    output logic                               link_train_en
);

    ecl_load_e            ld_state;
    logic                 fetch_start;
    logic                 fetch_busy;
    logic                 fetch_done;
    logic                 word_valid;
    logic [ECL_IDX_W-1:0] word_idx;
    logic [15:0]          word_data;
    logic                 word_absent;
    logic                 any_absent;
    logic                 reload_wr;
    logic                 setup;
    logic                 access;
    logic                 rd_wait;
    logic                 img_hit;
    logic                 mapped;
    logic [ECL_IDX_W-1:0] img_raddr;
    logic [15:0]          img_rdata;

    // ------------------------------------------------------------------
    // Load sequencing
    // ------------------------------------------------------------------
    assign fetch_start   = (ld_state == ECL_LD_BOOT) ||
                           ((ld_state == ECL_LD_READY) && reload_wr);
    assign link_train_en = (ld_state == ECL_LD_READY);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_state <= ECL_LD_BOOT;
        end else begin
            case (ld_state)
                ECL_LD_BOOT: begin
                    ld_state <= ECL_LD_BUSY;
                end
                ECL_LD_BUSY: begin
                    if (fetch_done) begin
                        ld_state <= ECL_LD_READY;
                    end
                end
                ECL_LD_READY: begin
                    if (reload_wr) begin
                        ld_state <= ECL_LD_BUSY;
                    end
                end
                default: begin
                    ld_state <= ECL_LD_BOOT;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            any_absent <= 1'b0;
        end else if (fetch_start) begin
            any_absent <= 1'b0;
        end else if (word_valid && word_absent) begin
            any_absent <= 1'b1;
        end
    end

    ecl_word_fetch u_fetch (
        .pclk        (pclk),
        .presetn     (presetn),
        .start       (fetch_start),
        .busy        (fetch_busy),
        .done        (fetch_done),
        .mem_req     (mem_req),
        .mem_addr    (mem_addr),
        .mem_ack     (mem_ack),
        .mem_absent  (mem_absent),
        .mem_rdata   (mem_rdata),
        .word_valid  (word_valid),
        .word_idx    (word_idx),
        .word_data   (word_data),
        .word_absent (word_absent)
    );

    ecl_image_ram u_image (
        .pclk  (pclk),
        .we    (word_valid),
        .waddr (word_idx),
        .wdata (word_data),
        .raddr (img_raddr),
        .rdata (img_rdata)
    );

    // ------------------------------------------------------------------
    // Field placement per port
    // ------------------------------------------------------------------
    for (genvar p = 0; p < ECL_NPORTS; p++) begin : g_port
        localparam logic [15:0] DEF_PHY = (p == 0) ? ECL_DEF_PHY_P0 : ECL_DEF_PHY;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                port_cfg[p].phy_param2                     <= DEF_PHY[4:0];
                port_cfg[p].phy_param3                     <= DEF_PHY[11:5];
                port_cfg[p].deemph_sel                     <= DEF_PHY[12];
                port_cfg[p].compl_to_detect                <= DEF_PHY[13];
                port_cfg[p].data_change_count_select       <= DEF_PHY[15:14];
                port_cfg[p].phy_pipe_control_word          <= {ECL_DEF_CSR_HI, ECL_DEF_CSR_LO};
            end else if (word_valid) begin
                if (word_idx == 4'(ECL_IDX_PHY + p)) begin
                    port_cfg[p].phy_param2                 <= word_data[4:0];
                    port_cfg[p].phy_param3                 <= word_data[11:5];
                    port_cfg[p].deemph_sel                 <= word_data[12];
                    port_cfg[p].compl_to_detect            <= word_data[13];
                    port_cfg[p].data_change_count_select   <= word_data[15:14];
                end
                if (word_idx == 4'(ECL_IDX_CSR_LO + p)) begin
                    port_cfg[p].phy_pipe_control_word[15:0]  <= word_data;
                end
                if (word_idx == 4'(ECL_IDX_CSR_HI + p)) begin
                    port_cfg[p].phy_pipe_control_word[31:16] <= word_data;
                end
            end
        end

        assign port_cfg[p].d1_support = 1'b1;
        assign port_cfg[p].d2_support = 1'b1;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                port_cfg[p].no_soft_reset <= ECL_DEF_PM[0];
                port_cfg[p].aux_current   <= ECL_DEF_PM[3:1];
                port_cfg[p].pme_support   <= ECL_DEF_PM[7:6];
                port_cfg[p].pm_data       <= ECL_DEF_PM[15:8];
            end else if (p < ECL_NPM_PORTS && word_valid &&
                         word_idx == 4'(ECL_IDX_PM + p)) begin
                port_cfg[p].no_soft_reset <= word_data[0];
                port_cfg[p].aux_current   <= word_data[3:1];
                port_cfg[p].pme_support   <= word_data[7:6];
                port_cfg[p].pm_data       <= word_data[15:8];
            end
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign setup     = psel && !penable;
    assign access    = psel && penable;
    assign img_hit   = (paddr >= ECL_REG_IMAGE) &&
                       (paddr < 12'(ECL_REG_IMAGE + 12'(4 * ECL_NWORDS))) &&
                       (paddr[1:0] == 2'b00);
    assign mapped    = img_hit || (paddr == ECL_REG_CTRL) || (paddr == ECL_REG_STATUS);
    assign img_raddr = 4'(paddr[11:2] - ECL_REG_IMAGE[11:2]);
    assign pready    = access && (pwrite || rd_wait);
    assign pslverr   = pready && !mapped;
    assign reload_wr = pready && pwrite && (paddr == ECL_REG_CTRL) &&
                       pwdata[ECL_CTRL_RELOAD];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_wait <= 1'b0;
        end else if (pready || setup) begin
            rd_wait <= 1'b0;
        end else if (access && !pwrite) begin
            rd_wait <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (access && !pwrite && !rd_wait) begin
            if (img_hit) begin
                prdata <= {16'h0000, img_rdata};
            end else if (paddr == ECL_REG_STATUS) begin
                prdata <= {29'h0000_0000, any_absent,
                           (ld_state == ECL_LD_READY), fetch_busy};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_word(int i);
        word_valid && word_idx == 4'(i);
    endsequence

    AST_PORT3_PARAM2: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_PHY + 3) |=> port_cfg[3].phy_param2 == $past(word_data[4:0]))
        else $error("port 3 parameter 2 not loaded");
    AST_PARAM3: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_PHY + 1) |=> port_cfg[1].phy_param3 == $past(word_data[11:5]))
        else $error("parameter 3 not loaded");
    AST_DEEMPH: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_PHY + 2) |=> port_cfg[2].deemph_sel == $past(word_data[12]))
        else $error("de-emphasis select not loaded");
    AST_COMPL: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_PHY) |=> port_cfg[0].compl_to_detect == $past(word_data[13]))
        else $error("compliance to detect not loaded");
    AST_DCCS: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_PHY + 3) |=>
            port_cfg[3].data_change_count_select == $past(word_data[15:14]))
        else $error("data change count select not loaded");
    AST_CSR_HI: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_CSR_HI + 2) |=>
            port_cfg[2].phy_pipe_control_word[31:16] == $past(word_data))
        else $error("control word upper half not loaded");
    AST_NOSRST: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_PM + 1) |=> port_cfg[1].no_soft_reset == $past(word_data[0]))
        else $error("no soft reset not loaded");
    AST_AUX: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_PM) |=> port_cfg[0].aux_current == $past(word_data[3:1]))
        else $error("aux current not loaded");
    AST_D1D2: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_PM) |=> port_cfg[0].d1_support && port_cfg[0].d2_support)
        else $error("power state support bits not one");
    AST_D2_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
        word_valid |-> ##1 (port_cfg[2].d2_support && $stable(port_cfg[2].d2_support)))
        else $error("D2 support bit changed");
    AST_PME: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_PM + 2) |=> port_cfg[2].pme_support == $past(word_data[7:6]))
        else $error("event support not loaded");
    AST_PMDATA: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_PM + 2) |=> port_cfg[2].pm_data == $past(word_data[15:8]))
        else $error("power data not loaded");
    AST_CSR_LO: assert property (@(posedge pclk) disable iff (!presetn)
        s_word(ECL_IDX_CSR_LO + 1) |=>
            port_cfg[1].phy_pipe_control_word[15:0] == $past(word_data))
        else $error("control word lower half not loaded");
    AST_TRAIN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        fetch_busy |-> !link_train_en)
        else $error("training enabled during load");
    AST_DONE_READY: assert property (@(posedge pclk) disable iff (!presetn)
        fetch_done |=> link_train_en ##1 (link_train_en || $past(reload_wr)))
        else $error("training not enabled after load");
    AST_ABSENT_DEF: assert property (@(posedge pclk) disable iff (!presetn)
        mem_req && mem_ack && mem_absent && mem_addr == 8'h50 |=>
            word_data == ECL_DEF_PM)
        else $error("absent word did not take its default");

endmodule
`default_nettype wire

// ---- testbench/ecl_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// Configuration memory model, prompt or slow, with one absent word.
// ------------------------------------------------------------------
module ecl_mem_model
    import ecl_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Word link
    input  wire logic       mem_req,
    input  wire logic [7:0] mem_addr,
    output logic            mem_ack,
    output logic            mem_absent,
    output logic      [15:0] mem_rdata,
    // Behaviour
    input  wire logic       slow,
    input  wire logic [7:0] absent_addr
);
    logic [1:0] wait_cnt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack    <= 1'b0;
            mem_absent <= 1'b0;
            mem_rdata  <= 16'h0000;
            wait_cnt   <= 2'h0;
        end else begin
            mem_ack    <= 1'b0;
            mem_absent <= 1'b0;
            mem_rdata  <= ~mem_rdata;
            if (mem_req && !mem_ack) begin
                if (!slow || wait_cnt == 2'h3) begin
                    mem_ack    <= 1'b1;
                    mem_absent <= (mem_addr == absent_addr);
                    mem_rdata  <= {mem_addr ^ 8'h5A, ~mem_addr};
                    wait_cnt   <= 2'h0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/eeprom_port_config_loader_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module eeprom_port_config_loader_tb;
    import ecl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, link_train_en;
    logic mem_req, mem_ack, mem_absent;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] mem_addr, absent_addr;
    logic [15:0] mem_rdata;
    logic er;
    ecl_cfg_port_s [ECL_NPORTS-1:0] port_cfg;
    int err_total, checked;
    logic [7:0]  ab_row [3] = '{8'hFF, 8'h50, 8'h46};
    logic [31:0] st_row [3] = '{32'h2, 32'h6, 32'h6};

    ecl_loader ecl_loader_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_absent(mem_absent), .mem_rdata(mem_rdata), .port_cfg(port_cfg),
        .link_train_en(link_train_en));
    ecl_mem_model ecl_mem_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_absent(mem_absent),
        .mem_rdata(mem_rdata), .slow(slow), .absent_addr(absent_addr));

    always #2 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Expected words and fields.
    // ------------------------------------------------------------------
    function automatic logic [15:0] wd(input int i, input logic [7:0] ab);
        logic [7:0] a;
        a = 8'h38 + 8'(2 * i);
        if (ab != a && ab != 8'h01) return {a ^ 8'h5A, ~a};
        if (i < 4) return 16'h0000;
        if (i == 4) return 16'h001D;
        if (i < 8) return 16'h101D;
        if (i < 12) return 16'h000F;
        return 16'h00FF;
    endfunction

    function automatic ecl_cfg_port_s ex(input int p, input logic [7:0] ab);
        logic [15:0] ph, pm;
        ecl_cfg_port_s c;
        ph = wd(4 + p, ab);
        pm = (p == 3) ? 16'h00FF : wd(12 + p, ab);
        c.phy_param2 = ph[4:0];
        c.phy_param3 = ph[11:5];
        c.deemph_sel = ph[12];
        c.compl_to_detect = ph[13];
        c.data_change_count_select = ph[15:14];
        c.phy_pipe_control_word = {wd(8 + p, ab), wd(p, ab)};
        c.no_soft_reset = pm[0];
        c.aux_current = pm[3:1];
        c.d1_support = 1'b1;
        c.d2_support = 1'b1;
        c.pme_support = pm[7:6];
        c.pm_data = pm[15:8];
        return c;
    endfunction

    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask

    task automatic cmp_cfg(input ecl_cfg_port_s g, input ecl_cfg_port_s e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t port fields %h expected %h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_load();
        int n;
        n = 0;
        while (link_train_en !== 1'b1 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        cmp32({31'h0, link_train_en}, 32'h1);
    endtask

    task automatic report_and_stop();
        if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Reset defaults, table of loads, then awkward cases.
    // ------------------------------------------------------------------
    initial begin
        {pclk, psel, penable, pwrite, slow, presetn} = '0;
        paddr = '0;
        pwdata = '0;
        absent_addr = 8'hFF;
        repeat (3) @(posedge pclk);
        for (int p = 0; p < 4; p++) cmp_cfg(port_cfg[p], ex(p, 8'h01));
        cmp32({30'h0, mem_req, link_train_en}, 32'h0);
        presetn <= 1'b1;
        for (int r = 0; r < 3; r++) begin
            if (r > 0) begin
                slow <= (r == 1);
                absent_addr <= ab_row[r];
                apb(1'b1, ECL_REG_CTRL, 32'h1);
                repeat (2) @(posedge pclk);
                cmp32({31'h0, link_train_en}, 32'h0);
            end
            wait_load();
            for (int p = 0; p < 4; p++) cmp_cfg(port_cfg[p], ex(p, ab_row[r]));
            for (int i = 0; i < 15; i++) begin
                apb(1'b0, ECL_REG_IMAGE + 12'(4 * i), 32'h0);
                cmp32(rd, {16'h0, wd(i, ab_row[r])});
            end
            apb(1'b0, ECL_REG_STATUS, 32'h0);
            cmp32(rd, st_row[r]);
        end
        apb(1'b0, 12'h0FC, 32'h0);
        cmp32(rd, 32'h0);
        cmp32({31'h0, er}, 32'h1);
        apb(1'b1, 12'h0FC, 32'h1);
        cmp32({31'h0, er}, 32'h1);
        cmp_cfg(port_cfg[2], ex(2, 8'h46));
        apb(1'b1, ECL_REG_CTRL, 32'h1);
        repeat (4) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        for (int p = 0; p < 4; p++) cmp_cfg(port_cfg[p], ex(p, 8'h01));
        cmp32({30'h0, mem_req, link_train_en}, 32'h0);
        presetn <= 1'b1;
        wait_load();
        for (int p = 0; p < 4; p++) cmp_cfg(port_cfg[p], ex(p, 8'h46));
        report_and_stop();
    end

    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
endmodule
`default_nettype wire
